/* rtl/pmc_pkg.sv */
// Package with the constants, types and register layout of the power mode controller.
package pmc_pkg;

  // Bus geometry.
  localparam int AW = 4;
  localparam int DW = 32;

  // Register byte offsets.
  localparam logic [AW-1:0] OFS_CTRL = 4'h0;
  localparam logic [AW-1:0] OFS_REGU = 4'h4;
  localparam logic [AW-1:0] OFS_STAT = 4'h8;
  localparam logic [AW-1:0] OFS_CFG  = 4'hC;

  // Control register fields.
  localparam int BIT_HALT  = 7;
  localparam int BIT_SLOW  = 6;
  localparam int BIT_ROI   = 5;
  localparam int BIT_DOE   = 4;
  localparam int RATIO_LSB = 0;
  localparam int RATIO_W   = 3;

  // Regulator register fields; the reserved bit reads as one.
  localparam int BIT_LPSEL = 1;
  localparam int BIT_RSVD  = 0;

  // Status register fields.
  localparam int BIT_TO_N = 4;
  localparam int BIT_PD_N = 3;
  localparam int MODE_LSB = 0;

  // Configuration register fields.
  localparam int OSC_LSB       = 0;
  localparam int BIT_WDT_SLEEP = 2;

  // Oscillator modes.
  localparam logic [1:0] OSC_CRYSTAL = 2'h0;
  localparam logic [1:0] OSC_EXT     = 2'h1;
  localparam logic [1:0] OSC_INT     = 2'h2;

  // Timing: clock rate, start-up and regulator recovery.
  localparam int CLK_PERIOD_NS = 100;
  localparam int OST_PERIODS   = 1024;
  localparam int LP_WAKE_NS    = 10000;
  localparam int LP_WAKE_CYC   = (LP_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Interrupt vector address.
  localparam logic [15:0] VECTOR_ADDR = 16'h0004;

  // Power modes.
  typedef enum logic [1:0] {
    PMC_RUN,
    PMC_SLEEP,
    PMC_IDLE,
    PMC_WAKE
  } pmc_mode_e;

  // Avalon-MM request from the master.
  typedef struct packed {
    logic          read;
    logic          write;
    logic [AW-1:0] address;
    logic [DW-1:0] writedata;
  } pmc_av_req_s;

endpackage

/* rtl/pmc_top.sv */
// Power mode controller: CPU throttling, Sleep and Idle sequencing.
//
// The implementer's own choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
module pmc_top
  import pmc_pkg::*;
#(
  parameter int OST_CYC = OST_PERIODS,
  parameter int LPW_CYC = LP_WAKE_CYC
) (
  // Clock and reset.
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  // Register bus.
  input  wire pmc_av_req_s i_av,
  output logic [DW-1:0]    o_av_readdata,
  output logic             o_av_waitrequest,
  // CPU core.
  input  wire logic        i_sleep_instr,
  input  wire logic        i_return_from_irq_instr_instr,
  input  wire logic        i_irq_req,
  input  wire logic        i_gie,
  output logic             o_cpu_cycle_en,
  output logic             o_prefetch_next,
  output logic             o_vector_go,
  output logic [15:0]      o_vector_addr,
  // Watchdog.
  input  wire logic        i_wdt_timeout,
  output logic             o_wdt_clear,
  output logic             o_wdt_run,
  output logic             o_wdt_reset_req,
  // External reset pin.
  input  wire logic        i_ext_reset_pin,
  output logic             o_sys_reset_req,
  // Clocks, regulator and pads.
  output logic             o_periph_clk_en,
  output logic             o_lf_osc_en,
  output logic             o_hf_osc_en,
  output logic             o_sec_osc_en,
  output logic             o_reg_lowpower,
  output logic             o_io_hold,
  // Status.
  output logic             o_powerdown_flag_n,
  output logic             o_timeout_flag_n,
  output logic [1:0]       o_mode
);

  // Software-visible control state.
  logic               halt_ff;
  logic               slow_ff;
  logic               nxt_slow;
  logic               roi_ff;
  logic               doe_ff;
  logic [RATIO_W-1:0] ratio_ff;
  logic               lpsel_ff;
  logic [1:0]         osc_ff;
  logic               wdts_ff;

  // Bus handshake.
  logic               wait_ff;
  logic               req;
  logic               acc;
  logic               wr_ctrl;
  logic               wr_regu;
  logic               wr_cfg;
  logic [DW-1:0]      rdata;

  // Sequencing state.
  pmc_mode_e          state_ff;
  pmc_mode_e          nxt_state;
  logic [15:0]        wcnt_ff;
  logic [15:0]        wake_len;
  logic               go_sleep;
  logic               wake_evt;
  logic               irq_entry;
  logic               vec_pend_ff;
  logic               in_isr_ff;

  // Throttle.
  logic [7:0]         cnt_ff;
  logic [7:0]         ratio_last;
  logic [7:0]         nxt_cnt;

  // Reset pin synchroniser.
  logic               rst_s1_ff;
  logic               rst_s2_ff;

  // Bus decode; a request is taken when waitrequest is already low.
  assign req     = i_av.read | i_av.write;
  assign acc     = req & ~wait_ff;
  assign wr_ctrl = acc & i_av.write & (i_av.address == OFS_CTRL);
  assign wr_regu = acc & i_av.write & (i_av.address == OFS_REGU);
  assign wr_cfg  = acc & i_av.write & (i_av.address == OFS_CFG);

  // Waitrequest drops for exactly one cycle per request.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wait_ff <= 1'b1;
    end else begin
      wait_ff <= ~(req & wait_ff);
    end
  end

  // Read mux; unmapped addresses return zero.
  always_comb begin
    rdata = '0;
    unique case (i_av.address)
      OFS_CTRL: begin
        rdata[BIT_HALT]                   = halt_ff;
        rdata[BIT_SLOW]                   = slow_ff;
        rdata[BIT_ROI]                    = roi_ff;
        rdata[BIT_DOE]                    = doe_ff;
        rdata[RATIO_LSB +: RATIO_W]       = ratio_ff;
      end
      OFS_REGU: begin
        rdata[BIT_LPSEL]                  = lpsel_ff;
        rdata[BIT_RSVD]                   = 1'b1;
      end
      OFS_STAT: begin
        rdata[BIT_TO_N]                   = o_timeout_flag_n;
        rdata[BIT_PD_N]                   = o_powerdown_flag_n;
        rdata[MODE_LSB +: 2]              = state_ff;
      end
      OFS_CFG: begin
        rdata[OSC_LSB +: 2]               = osc_ff;
        rdata[BIT_WDT_SLEEP]              = wdts_ff;
      end
      default: begin
        rdata = '0;
      end
    endcase
  end

  // Read data is captured while waitrequest is high so it stands at the ack edge.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_av_readdata <= '0;
    end else if (req & wait_ff) begin
      o_av_readdata <= i_av.read ? rdata : '0;
    end
  end

  assign o_av_waitrequest = wait_ff;

  // Plain control bits written by software.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      halt_ff  <= 1'b0;
      roi_ff   <= 1'b0;
      doe_ff   <= 1'b0;
      ratio_ff <= '0;
      lpsel_ff <= 1'b0;
      osc_ff   <= OSC_CRYSTAL;
      wdts_ff  <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        halt_ff  <= i_av.writedata[BIT_HALT];
        roi_ff   <= i_av.writedata[BIT_ROI];
        doe_ff   <= i_av.writedata[BIT_DOE];
        ratio_ff <= i_av.writedata[RATIO_LSB +: RATIO_W];
      end
      if (wr_regu) begin
        lpsel_ff <= i_av.writedata[BIT_LPSEL];
      end
      if (wr_cfg) begin
        osc_ff  <= i_av.writedata[OSC_LSB +: 2];
        wdts_ff <= i_av.writedata[BIT_WDT_SLEEP];
      end
    end
  end

  // Interrupt entry is only seen while running and not already in a handler.
  assign irq_entry = (state_ff == PMC_RUN) & i_irq_req & i_gie & ~in_isr_ff & ~vec_pend_ff;

  // Throttle enable: hardware actions override a software write in the same cycle.
  always_comb begin
    nxt_slow = slow_ff;
    if (wr_ctrl) begin
      nxt_slow = i_av.writedata[BIT_SLOW];
    end
    if (irq_entry & roi_ff) begin
      nxt_slow = 1'b0;
    end
    if (i_return_from_irq_instr_instr & doe_ff) begin
      nxt_slow = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      slow_ff   <= 1'b0;
    end else begin
      slow_ff   <= nxt_slow;
    end
  end

  // Ratio is two to the power of select plus one.
  assign ratio_last = 8'((9'h002 << ratio_ff) - 9'h001);

  // Throttle phase counter, restarted in the very cycle throttling turns on.
  // The enable below looks at the next count, so the first throttled period is never cut short.
  always_comb begin
    nxt_cnt = cnt_ff + 8'h01;
    if ((nxt_slow & ~slow_ff) | (cnt_ff >= ratio_last)) begin
      nxt_cnt = '0;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // CPU and flash run one cycle in N when throttled, never in Sleep or Idle.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_cpu_cycle_en <= 1'b0;
    end else begin
      o_cpu_cycle_en <= (nxt_state == PMC_RUN) & (~nxt_slow | (nxt_cnt == 8'h00));
    end
  end

  // Vectoring waits for one executed cycle, so the prefetched instruction runs first.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      vec_pend_ff <= 1'b0;
      o_vector_go <= 1'b0;
      in_isr_ff   <= 1'b0;
    end else begin
      o_vector_go <= vec_pend_ff & o_cpu_cycle_en;
      if (irq_entry) begin
        vec_pend_ff <= 1'b1;
      end else if (o_cpu_cycle_en) begin
        vec_pend_ff <= 1'b0;
      end
      if (vec_pend_ff & o_cpu_cycle_en) begin
        in_isr_ff <= 1'b1;
      end else if (i_return_from_irq_instr_instr) begin
        in_isr_ff <= 1'b0;
      end
    end
  end

  // A pending enabled interrupt with global enable off turns sleep into a no-op.
  assign go_sleep = (state_ff == PMC_RUN) & i_sleep_instr & ~(i_irq_req & ~i_gie);

  // Wake sources; resets act through the reset itself.
  assign wake_evt = i_irq_req | i_wdt_timeout;

  // Start-up length: oscillator settling plus regulator recovery.
  always_comb begin
    wake_len = '0;
    if (osc_ff == OSC_CRYSTAL) begin
      wake_len = 16'(OST_CYC);
    end
    if (lpsel_ff) begin
      wake_len = wake_len + 16'(LPW_CYC);
    end
  end

  // Mode sequencer.
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      PMC_RUN: begin
        if (go_sleep) begin
          nxt_state = halt_ff ? PMC_IDLE : PMC_SLEEP;
        end
      end
      PMC_SLEEP: begin
        if (wake_evt) begin
          nxt_state = (wake_len == 16'h0000) ? PMC_RUN : PMC_WAKE;
        end
      end
      PMC_IDLE: begin
        if (wake_evt) begin
          nxt_state = PMC_RUN;
        end
      end
      PMC_WAKE: begin
        if (wcnt_ff <= 16'h0001) begin
          nxt_state = PMC_RUN;
        end
      end
    endcase
  end

  // Mode state and start-up counter.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_ff <= PMC_RUN;
      wcnt_ff  <= '0;
    end else begin
      state_ff <= nxt_state;
      if ((state_ff == PMC_SLEEP) & wake_evt) begin
        wcnt_ff <= wake_len;
      end else if (wcnt_ff != 16'h0000) begin
        wcnt_ff <= wcnt_ff - 16'h0001;
      end
    end
  end

  // Status flags; a no-op sleep leaves both untouched.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_powerdown_flag_n <= 1'b1;
      o_timeout_flag_n   <= 1'b1;
    end else if (go_sleep) begin
      o_powerdown_flag_n <= 1'b0;
      o_timeout_flag_n   <= 1'b1;
    end else if ((state_ff == PMC_SLEEP) & i_wdt_timeout & ~i_irq_req) begin
      o_timeout_flag_n   <= 1'b0;
    end
  end

  // Watchdog: cleared on entry and on every exit, runs in Sleep only when configured.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_wdt_clear     <= 1'b0;
      o_wdt_run       <= 1'b1;
      o_wdt_reset_req <= 1'b0;
    end else begin
      o_wdt_clear     <= go_sleep | ((state_ff != PMC_RUN) & (state_ff != PMC_WAKE) & wake_evt);
      o_wdt_run       <= (nxt_state == PMC_SLEEP) ? wdts_ff : 1'b1;
      o_wdt_reset_req <= i_wdt_timeout & ((state_ff == PMC_RUN) | (state_ff == PMC_WAKE));
    end
  end

  // Prefetch of the following instruction during the sleep instruction.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_prefetch_next <= 1'b0;
    end else begin
      o_prefetch_next <= (state_ff == PMC_RUN) & i_sleep_instr;
    end
  end

  // Peripheral clocks stop only in Sleep and start-up; pads hold meanwhile.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_periph_clk_en <= 1'b1;
      o_io_hold       <= 1'b0;
      o_reg_lowpower  <= 1'b0;
      o_mode          <= 2'h0;
    end else begin
      o_periph_clk_en <= (nxt_state == PMC_RUN) | (nxt_state == PMC_IDLE);
      o_io_hold       <= (nxt_state == PMC_SLEEP) | (nxt_state == PMC_WAKE);
      o_reg_lowpower  <= (nxt_state == PMC_SLEEP) & lpsel_ff;
      o_mode          <= nxt_state;
    end
  end

  // Internal and secondary oscillators are never stopped by this block.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_lf_osc_en   <= 1'b1;
      o_hf_osc_en   <= 1'b1;
      o_sec_osc_en  <= 1'b1;
      o_vector_addr <= VECTOR_ADDR;
    end else begin
      o_lf_osc_en   <= 1'b1;
      o_hf_osc_en   <= 1'b1;
      o_sec_osc_en  <= 1'b1;
      o_vector_addr <= VECTOR_ADDR;
    end
  end

  // The reset pin is synchronised and passed on whatever the mode.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_s1_ff       <= 1'b0;
      rst_s2_ff       <= 1'b0;
      o_sys_reset_req <= 1'b0;
    end else begin
      rst_s1_ff       <= i_ext_reset_pin;
      rst_s2_ff       <= rst_s1_ff;
      o_sys_reset_req <= rst_s2_ff;
    end
  end

endmodule

/* verif/pmc_sva.sv */
// Port checker for the power mode controller, bound into the top module.
`timescale 1ns/1ps
module pmc_sva
  import pmc_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_arst_n,
  input wire pmc_av_req_s i_av,
  input wire logic        o_av_waitrequest,
  input wire logic        i_sleep_instr,
  input wire logic        i_irq_req,
  input wire logic        i_gie,
  input wire logic        i_wdt_timeout,
  input wire logic        i_ext_reset_pin,
  input wire logic        o_cpu_cycle_en,
  input wire logic        o_prefetch_next,
  input wire logic        o_vector_go,
  input wire logic [15:0] o_vector_addr,
  input wire logic        o_wdt_clear,
  input wire logic        o_wdt_reset_req,
  input wire logic        o_sys_reset_req,
  input wire logic        o_periph_clk_en,
  input wire logic        o_lf_osc_en,
  input wire logic        o_hf_osc_en,
  input wire logic        o_sec_osc_en,
  input wire logic        o_io_hold,
  input wire logic        o_powerdown_flag_n,
  input wire logic        o_timeout_flag_n,
  input wire logic [1:0]  o_mode
);
  // All checks share the one clock and its asynchronous reset.
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  // A sleep instruction taken while running, and the state just after a wake.
  sequence s_sleep_req;
    o_mode == PMC_RUN && i_sleep_instr;
  endsequence
  sequence s_woken;
    (o_mode == PMC_WAKE || o_mode == PMC_RUN) && o_wdt_clear;
  endsequence

  property p_wait;
    (i_av.read || i_av.write) && o_av_waitrequest |=> !o_av_waitrequest;
  endproperty
  property p_osc;
    o_lf_osc_en && o_hf_osc_en && o_sec_osc_en;
  endproperty
  property p_run_clk;
    (o_mode == PMC_RUN || o_mode == PMC_IDLE) |-> o_periph_clk_en;
  endproperty
  property p_sleep_hold;
    o_mode == PMC_SLEEP |-> !o_periph_clk_en && o_io_hold && !o_cpu_cycle_en;
  endproperty
  property p_enter;
    $rose(o_mode == PMC_SLEEP) |-> !o_powerdown_flag_n && o_timeout_flag_n && o_wdt_clear;
  endproperty
  property p_prefetch;
    s_sleep_req |=> o_prefetch_next;
  endproperty
  property p_noop;
    o_mode == PMC_RUN && i_sleep_instr && i_irq_req && !i_gie |=>
      o_mode == PMC_RUN && !o_wdt_clear && $stable(o_powerdown_flag_n) && $stable(o_timeout_flag_n);
  endproperty
  property p_sleep_wake;
    o_mode == PMC_SLEEP && i_irq_req |=> s_woken;
  endproperty
  property p_idle;
    o_mode == PMC_IDLE |-> o_periph_clk_en && !o_cpu_cycle_en;
  endproperty
  property p_idle_wake;
    o_mode == PMC_IDLE && (i_irq_req || i_wdt_timeout) |=> o_mode == PMC_RUN;
  endproperty
  property p_wdt_block;
    (o_mode == PMC_SLEEP || o_mode == PMC_IDLE) && i_wdt_timeout |=> !o_wdt_reset_req;
  endproperty
  property p_ext;
    o_sys_reset_req == $past(i_ext_reset_pin, 3);
  endproperty
  property p_vec;
    o_vector_addr == VECTOR_ADDR;
  endproperty
  property p_vec_order;
    $rose(o_vector_go) |-> $past(o_cpu_cycle_en);
  endproperty

  a_wait: assert property (p_wait) else $error("bus answer late");
  a_osc: assert property (p_osc) else $error("oscillator stopped");
  a_run_clk: assert property (p_run_clk) else $error("peripheral clock gated");
  a_sleep_hold: assert property (p_sleep_hold) else $error("sleep state wrong");
  a_enter: assert property (p_enter) else $error("sleep entry flags wrong");
  a_prefetch: assert property (p_prefetch) else $error("no prefetch");
  a_noop: assert property (p_noop) else $error("sleep not a no-op");
  a_sleep_wake: assert property (p_sleep_wake) else $error("no wake");
  a_idle: assert property (p_idle) else $error("idle clocks wrong");
  a_idle_wake: assert property (p_idle_wake) else $error("idle kept");
  a_wdt_block: assert property (p_wdt_block) else $error("watchdog reset in low power");
  a_ext: assert property (p_ext) else $error("reset pin path wrong");
  a_vec: assert property (p_vec) else $error("vector address wrong");
  a_vec_order: assert property (p_vec_order) else $error("vector before prefetched cycle");
endmodule

bind pmc_top pmc_sva chk_u (.i_clk, .i_arst_n, .i_av, .o_av_waitrequest, .i_sleep_instr, .i_irq_req,
  .i_gie, .i_wdt_timeout, .i_ext_reset_pin, .o_cpu_cycle_en, .o_prefetch_next, .o_vector_go, .o_vector_addr,
  .o_wdt_clear, .o_wdt_reset_req, .o_sys_reset_req, .o_periph_clk_en, .o_lf_osc_en, .o_hf_osc_en,
  .o_sec_osc_en, .o_io_hold, .o_powerdown_flag_n, .o_timeout_flag_n, .o_mode);

/* verif/pmc_wdt_model.sv */
// Watchdog counter model that follows the controller's clear and run outputs.
`timescale 1ns/1ps
module pmc_wdt_model (
  input  wire logic   i_clk,
  input  wire logic   i_arst_n,
  input  wire logic   i_clear,
  input  wire logic   i_run,
  output logic [15:0] o_count
);
  // Clear wins over counting, so a wake never leaves a stale count behind.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_count <= 16'h0000;
    end else if (i_clear) begin
      o_count <= 16'h0000;
    end else if (i_run) begin
      o_count <= o_count + 16'h0001;
    end
  end
endmodule

/* verif/testbench.sv */
// Self-checking testbench for the power mode controller.
`timescale 1ns/1ps
module testbench;
  import pmc_pkg::*;
  localparam int OSTC = 8;
  localparam int LPWC = 4;
  logic        i_clk = 1'b0;
  logic        i_arst_n = 1'b0;
  pmc_av_req_s i_av = '0;
  logic        i_sleep_instr = 1'b0;
  logic        i_return_from_irq_instr_instr = 1'b0;
  logic        i_irq_req = 1'b0;
  logic        i_gie = 1'b0;
  logic        i_wdt_timeout = 1'b0;
  logic        i_ext_reset_pin = 1'b0;
  logic [31:0] o_av_readdata;
  logic        o_av_waitrequest, o_cpu_cycle_en, o_prefetch_next, o_vector_go, o_wdt_clear, o_wdt_run;
  logic        o_wdt_reset_req, o_sys_reset_req, o_periph_clk_en, o_lf_osc_en, o_hf_osc_en, o_sec_osc_en;
  logic        o_reg_lowpower, o_io_hold, o_powerdown_flag_n, o_timeout_flag_n;
  logic [15:0] o_vector_addr, wdt_count;
  logic [1:0]  o_mode;
  int          bad_count = 0;
  int          total_checks = 0;
  int          n, n2, k, r;

  // The clock period is 100 ns.
  always #50 i_clk = ~i_clk;

  // Small start-up counts keep the sleep runs short.
  pmc_top #(.OST_CYC(OSTC), .LPW_CYC(LPWC)) dut_u (.i_clk, .i_arst_n, .i_av, .o_av_readdata,
    .o_av_waitrequest, .i_sleep_instr, .i_return_from_irq_instr_instr, .i_irq_req, .i_gie, .o_cpu_cycle_en,
    .o_prefetch_next, .o_vector_go, .o_vector_addr, .i_wdt_timeout, .o_wdt_clear, .o_wdt_run,
    .o_wdt_reset_req, .i_ext_reset_pin, .o_sys_reset_req, .o_periph_clk_en, .o_lf_osc_en,
    .o_hf_osc_en, .o_sec_osc_en, .o_reg_lowpower, .o_io_hold, .o_powerdown_flag_n,
    .o_timeout_flag_n, .o_mode);

  pmc_wdt_model wdt_u (.i_clk, .i_arst_n, .i_clear(o_wdt_clear), .i_run(o_wdt_run), .o_count(wdt_count));

  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // One Avalon transfer: held until waitrequest is sampled low, then released.
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    i_av <= '{read: !wr, write: wr, address: a, writedata: d};
    do @(posedge i_clk); while (o_av_waitrequest !== 1'b0);
    q = o_av_readdata;
    i_av <= '0;
    @(posedge i_clk);
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task rd(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q, exp);
  endtask

  task do_sleep;
    i_sleep_instr <= 1'b1;
    @(posedge i_clk);
    i_sleep_instr <= 1'b0;
    repeat (2) @(posedge i_clk);
  endtask
  task do_return_from_irq_instr;
    i_return_from_irq_instr_instr <= 1'b1;
    @(posedge i_clk);
    i_return_from_irq_instr_instr <= 1'b0;
    @(posedge i_clk);
  endtask

  // Edges from the wake request until the controller is running again.
  task wake_time(output int w);
    w = 0;
    do begin
      @(posedge i_clk);
      w++;
    end while (o_mode !== PMC_RUN && w < 3000);
    i_irq_req <= 1'b0;
    @(posedge i_clk);
  endtask
  task wait_vec;
    int t;
    t = 0;
    while (o_vector_go !== 1'b1 && t < 1000) begin
      @(posedge i_clk);
      t++;
    end
    check(t < 1000, 1'b1);
    i_irq_req <= 1'b0;
    @(posedge i_clk);
  endtask

  task final_report;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // A hang counts as a mismatch.
  initial begin
    repeat (20000) @(posedge i_clk);
    bad_count++;
    final_report();
  end

  initial begin
    repeat (16) @(posedge i_clk);
    i_arst_n <= 1'b1;
    @(posedge i_clk);
    rd(OFS_CTRL, 32'h0);
    rd(OFS_REGU, 32'h1);
    rd(OFS_CFG, 32'h0);
    rd(4'h2, 32'h0);
    wr(OFS_STAT, 32'hFF);
    rd(OFS_STAT, 32'h18);
    // Every ratio: four enabled cycles in four whole periods.
    for (r = 0; r < 8; r++) begin
      wr(OFS_CTRL, 32'h40 | r);
      k = 0;
      repeat ((2 << r) * 4) begin
        @(posedge i_clk);
        if (o_cpu_cycle_en === 1'b1) k++;
      end
      check(k, 4);
    end
    wr(OFS_CTRL, 32'h40);
    i_gie <= 1'b1;
    i_irq_req <= 1'b1;
    wait_vec();
    rd(OFS_CTRL, 32'h40);
    do_return_from_irq_instr();
    wr(OFS_CTRL, 32'h70);
    i_irq_req <= 1'b1;
    wait_vec();
    rd(OFS_CTRL, 32'h30);
    do_return_from_irq_instr();
    rd(OFS_CTRL, 32'h70);
    // Sleep wake lengths for each oscillator and regulator choice.
    wr(OFS_CTRL, 32'h0);
    i_gie <= 1'b0;
    do_sleep();
    rd(OFS_STAT, 32'h11);
    check(wdt_count, 16'h0);
    check(o_wdt_run, 1'b0);
    i_irq_req <= 1'b1;
    wake_time(n);
    wr(OFS_CFG, 32'h2);
    do_sleep();
    i_irq_req <= 1'b1;
    wake_time(n2);
    check(n - n2, OSTC);
    wr(OFS_CFG, 32'h1);
    do_sleep();
    i_irq_req <= 1'b1;
    wake_time(n);
    check(n, n2);
    wr(OFS_REGU, 32'h3);
    wr(OFS_CFG, 32'h2);
    do_sleep();
    check(o_reg_lowpower, 1'b1);
    i_irq_req <= 1'b1;
    wake_time(n);
    check(n - n2, LPWC);
    wr(OFS_REGU, 32'h1);
    wr(OFS_CFG, 32'h6);
    do_sleep();
    check(o_wdt_run, 1'b1);
    i_wdt_timeout <= 1'b1;
    @(posedge i_clk);
    i_wdt_timeout <= 1'b0;
    wake_time(n);
    rd(OFS_STAT, 32'h0);
    // A pending interrupt makes sleep a no-op; a late one wakes at once.
    i_irq_req <= 1'b1;
    do_sleep();
    rd(OFS_STAT, 32'h0);
    i_irq_req <= 1'b0;
    i_sleep_instr <= 1'b1;
    @(posedge i_clk);
    i_sleep_instr <= 1'b0;
    i_irq_req <= 1'b1;
    wake_time(n);
    check(n, 2);
    rd(OFS_STAT, 32'h10);
    i_gie <= 1'b1;
    do_sleep();
    i_irq_req <= 1'b1;
    wait_vec();
    do_return_from_irq_instr();
    // Idle ends on an interrupt or a watchdog timeout.
    i_gie <= 1'b0;
    wr(OFS_CTRL, 32'h80);
    do_sleep();
    check(o_mode, PMC_IDLE);
    check(o_periph_clk_en, 1'b1);
    i_irq_req <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_irq_req <= 1'b0;
    check(o_mode, PMC_RUN);
    rd(OFS_CTRL, 32'h80);
    do_sleep();
    i_wdt_timeout <= 1'b1;
    @(posedge i_clk);
    i_wdt_timeout <= 1'b0;
    @(posedge i_clk);
    check(o_mode, PMC_RUN);
    check(o_wdt_reset_req, 1'b0);
    i_ext_reset_pin <= 1'b1;
    repeat (5) @(posedge i_clk);
    check(o_sys_reset_req, 1'b1);
    i_ext_reset_pin <= 1'b0;
    repeat (5) @(posedge i_clk);
    check(o_sys_reset_req, 1'b0);
    final_report();
  end
endmodule
